// ===== src/sfam_defines.svh
`ifndef SFAM_DEFINES_SVH
`define SFAM_DEFINES_SVH
// register byte addresses on the apb slave
`define SFAM_A_CTRL      12'h000
`define SFAM_A_LIM_ICUR  12'h004
`define SFAM_A_LIM_VMAX  12'h008
`define SFAM_A_LIM_UCUR  12'h00C
`define SFAM_A_LIM_UVMAX 12'h010
`define SFAM_A_LIM_UVMIN 12'h014
`define SFAM_A_LIM_TEMP  12'h018
`define SFAM_A_LIM_LOWV  12'h01C
`define SFAM_A_STATUS    12'h020
`define SFAM_A_CMD       12'h024
// control register bit positions
`define SFAM_C_LOWV_EN   0
`define SFAM_C_OVHT_EN   1
`define SFAM_C_BRDG_EN   2
`define SFAM_C_MISS_EN   3
`define SFAM_C_STICKY    4
`define SFAM_C_USBRC_EN  5
`define SFAM_C_TEMP_EN   6
// command register bit: stop
`define SFAM_CMD_STOP    0
// limit and control reset values
`define SFAM_RST_ICUR    16'h0FA0
`define SFAM_RST_VMAX    16'hFFFF
`define SFAM_RST_UCUR    16'h01C2
`define SFAM_RST_UVMAX   16'h1450
`define SFAM_RST_UVMIN   16'h1068
`define SFAM_RST_TEMP    16'h0050
`define SFAM_RST_LOWV    16'h1F40
`define SFAM_RST_CTRL    7'h00
// usb reconnect pulse length in clock cycles
`define SFAM_USBRST_CYC  8'h10
`endif

// ===== src/sfam_monitor.sv
// Contract
// R1 - any current, voltage or temperature out of range switches off every power output and raises the alarm.
// R2 - limits are held for input current, input voltage, usb current, usb max and min voltage and temperature, temperature only when measured.
// R3 - with low-voltage protection enabled, input voltage at or below its threshold raises the alarm.
// R4 - with overheat shutdown enabled, a driver overheat indication raises the alarm and turns off the driver.
// R5 - with bridge-fault option enabled, the driver malfunction signal raises the alarm and turns off the driver.
// R6 - with edge-misset enabled, the right switch while moving left or left switch while moving right raises the alarm.
// R7 - without sticky mode the alarm clears by itself once its cause is gone.
// R8 - in sticky mode alarm and cause stay latched until the host issues a stop command.
// R9 - with usb reconnect enabled, a broken host link resets the usb link.
// R10 - a readable status shows alarm active, its cause and whether the value was below or above its limit.
`timescale 1ns/1ps
`include "sfam_defines.svh"
module sfam_monitor
  import sfam_pkg::*;
#(
  parameter int LW = 16
)(
  // clock and reset
  input  wire logic             CLK_SYS,
  input  wire logic             RST,
  // apb slave
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [11:0]      PADDR,
  input  wire logic [31:0]      PWDATA,
  output logic      [31:0]      PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  // monitored quantities and events
  input  wire sfam_meas_s       MEAS,
  input  wire sfam_evt_s        EVT,
  // protection outputs
  output logic                  PWR_EN,
  output logic                  DRV_EN,
  output logic                  ALARM,
  output logic                  USB_LINK_RST
);
  localparam int NC = SFAM_K_N;

  // register state
  logic [6:0]    ctrl_r, ctrl_nxt;
  // limits indexed by word offset minus one: entry 0 is the input current limit
  logic [LW-1:0] lim_r [7];
  logic [LW-1:0] lim_nxt [7];
  logic [NC-1:0] cause_r, cause_nxt, live;
  sfam_state_e   st_r, st_nxt;
  logic [31:0]   prdata_r, prdata_nxt;
  logic          pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic          pwr_r, pwr_nxt, drv_r, drv_nxt;
  logic [7:0]    urst_cnt_r, urst_cnt_nxt;
  logic          link_prev_r, link_prev_nxt;
  logic          alarm_r, alarm_nxt;
  logic          usb_rst_r, usb_rst_nxt;
  logic          stop_cmd, acc, wr, hit;

  // a transfer is taken once, on its access edge; the ready cycle after it is ignored
  assign acc = PSEL && PENABLE && !pready_r;
  assign wr  = acc && PWRITE;
  assign stop_cmd = wr && PADDR == `SFAM_A_CMD && PWDATA[`SFAM_CMD_STOP];

  // live fault conditions; temperature, low voltage and the event faults are gated by their options
  // a value sitting exactly on a max or min limit is still good; low voltage trips at its threshold
  always_comb
  begin
    live = '0;
    live[SFAM_K_ICUR_HI] = MEAS.icur  > lim_r[0];                  // see R1
    live[SFAM_K_VIN_HI]  = MEAS.vin   > lim_r[1];                  // see R2
    live[SFAM_K_UCUR_HI] = MEAS.ucur  > lim_r[2];
    live[SFAM_K_UV_HI]   = MEAS.uvolt > lim_r[3];
    live[SFAM_K_UV_LO]   = MEAS.uvolt < lim_r[4];
    live[SFAM_K_TEMP_HI] = ctrl_r[`SFAM_C_TEMP_EN] && MEAS.temp > lim_r[5];   // see R2
    live[SFAM_K_VIN_LO]  = ctrl_r[`SFAM_C_LOWV_EN] && MEAS.vin <= lim_r[6];   // see R3
    live[SFAM_K_OVHT]    = ctrl_r[`SFAM_C_OVHT_EN] && EVT.ovht;               // see R4
    live[SFAM_K_BRDG]    = ctrl_r[`SFAM_C_BRDG_EN] && EVT.brdg;               // see R5
    live[SFAM_K_MISS]    = ctrl_r[`SFAM_C_MISS_EN] &&                         // see R6
                           ((EVT.lsw_right && EVT.mov_left) || (EVT.lsw_left && EVT.mov_right));
  end

  // alarm state and cause; a fault present in the stop cycle re-latches, so it is never lost
  always_comb
  begin
    cause_nxt = cause_r;
    st_nxt    = st_r;
    if (ctrl_r[`SFAM_C_STICKY])
    begin
      cause_nxt = (stop_cmd ? '0 : cause_r) | live;                          // see R8
    end
    else
    begin
      cause_nxt = live;                                                      // see R7
    end
    st_nxt = (cause_nxt != '0) ? SFAM_ALARM : SFAM_IDLE;                     // see R1
    // power outputs off while alarmed; registered from the next state so they change on the same edge as the state
    pwr_nxt = (st_nxt == SFAM_IDLE);                                         // see R1
    drv_nxt = (st_nxt == SFAM_IDLE);                                         // see R4 see R5
    // alarm pin registered from the next state so it lines up with the enables
    alarm_nxt = (st_nxt == SFAM_ALARM);                                      // see R1
  end

  // usb reconnect: a rising edge of link-broken starts a fixed reset pulse
  always_comb
  begin
    link_prev_nxt = EVT.link_broken;
    urst_cnt_nxt  = (urst_cnt_r != 8'h00) ? urst_cnt_r - 8'h01 : 8'h00;
    if (ctrl_r[`SFAM_C_USBRC_EN] && EVT.link_broken && !link_prev_r)
    begin
      urst_cnt_nxt = `SFAM_USBRST_CYC;                                       // see R9
    end
    // only an edge restarts the link; a link that stays broken is reset once
    usb_rst_nxt = (urst_cnt_nxt != 8'h00);
  end

  // apb register file; answers in the access cycle's first edge
  always_comb
  begin
    ctrl_nxt    = ctrl_r;
    lim_nxt     = lim_r;
    prdata_nxt  = prdata_r;
    pready_nxt  = acc;
    pslverr_nxt = 1'b0;
    // unmapped offsets answer with an error and change nothing
    hit         = 1'b1;
    if (acc)
    begin
      prdata_nxt = 32'h0000_0000;
      unique case (PADDR)
        `SFAM_A_CTRL:
        begin
          if (PWRITE) ctrl_nxt = PWDATA[6:0];
          prdata_nxt = {25'h0, ctrl_r};
        end
        `SFAM_A_LIM_ICUR, `SFAM_A_LIM_VMAX, `SFAM_A_LIM_UCUR, `SFAM_A_LIM_UVMAX,
        `SFAM_A_LIM_UVMIN, `SFAM_A_LIM_TEMP, `SFAM_A_LIM_LOWV:
        begin
          if (PWRITE) lim_nxt[PADDR[4:2] - 3'h1] = PWDATA[LW-1:0];
          prdata_nxt[LW-1:0] = lim_r[PADDR[4:2] - 3'h1];
        end
        `SFAM_A_STATUS:
          prdata_nxt = {15'h0, st_r == SFAM_ALARM, 6'h0, cause_r};             // see R10
        `SFAM_A_CMD:
          prdata_nxt = 32'h0000_0000;
        default:
          hit = 1'b0;
      endcase
      pslverr_nxt = !hit;
    end
  end

  // fault state registers; reset keeps every power output off until the first clean edge
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      cause_r <= '0;
      st_r    <= SFAM_IDLE;
      alarm_r <= 1'b0;
      pwr_r   <= 1'b0;
      drv_r   <= 1'b0;
    end
    else
    begin
      cause_r <= cause_nxt;
      st_r    <= st_nxt;
      alarm_r <= alarm_nxt;
      pwr_r   <= pwr_nxt;
      drv_r   <= drv_nxt;
    end
  end

  // usb reconnect registers
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      urst_cnt_r  <= 8'h00;
      link_prev_r <= 1'b0;
      usb_rst_r   <= 1'b0;
    end
    else
    begin
      urst_cnt_r  <= urst_cnt_nxt;
      link_prev_r <= link_prev_nxt;
      usb_rst_r   <= usb_rst_nxt;
    end
  end

  // apb register file registers
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      ctrl_r    <= `SFAM_RST_CTRL;
      lim_r[0]  <= `SFAM_RST_ICUR;
      lim_r[1]  <= `SFAM_RST_VMAX;
      lim_r[2]  <= `SFAM_RST_UCUR;
      lim_r[3]  <= `SFAM_RST_UVMAX;
      lim_r[4]  <= `SFAM_RST_UVMIN;
      lim_r[5]  <= `SFAM_RST_TEMP;
      lim_r[6]  <= `SFAM_RST_LOWV;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      ctrl_r    <= ctrl_nxt;
      lim_r     <= lim_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // outputs straight from flops
  assign PRDATA       = prdata_r;
  assign PREADY       = pready_r;
  assign PSLVERR      = pslverr_r;
  assign PWR_EN       = pwr_r;
  assign DRV_EN       = drv_r;
  assign ALARM        = alarm_r;
  assign USB_LINK_RST = usb_rst_r;
endmodule

// ===== src/sfam_pkg.sv
package sfam_pkg;
  // measured values from the converters
  typedef struct packed {
    logic [15:0] icur;
    logic [15:0] vin;
    logic [15:0] ucur;
    logic [15:0] uvolt;
    logic [15:0] temp;
  } sfam_meas_s;
  // discrete fault and motion inputs
  typedef struct packed {
    logic ovht;
    logic brdg;
    logic lsw_left;
    logic lsw_right;
    logic mov_left;
    logic mov_right;
    logic link_broken;
  } sfam_evt_s;
  typedef enum logic [1:0] {SFAM_IDLE, SFAM_ALARM} sfam_state_e;
  // cause bit indices in the status word
  typedef enum int {
    SFAM_K_ICUR_HI, SFAM_K_VIN_HI, SFAM_K_UCUR_HI, SFAM_K_UV_HI, SFAM_K_UV_LO,
    SFAM_K_TEMP_HI, SFAM_K_VIN_LO, SFAM_K_OVHT, SFAM_K_BRDG, SFAM_K_MISS, SFAM_K_N
  } sfam_cause_e;
endpackage

// ===== test/sfam_chk_monitor.sv
`timescale 1ns/1ps
module sfam_chk
  import sfam_pkg::*;
(
  // clock, reset and bus
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // monitor side
  input wire sfam_meas_s  MEAS,
  input wire sfam_evt_s   EVT,
  input wire logic        PWR_EN,
  input wire logic        DRV_EN,
  input wire logic        ALARM,
  input wire logic        USB_LINK_RST
);
  logic [6:0] c_r, c_nxt;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_acc;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence s_ack;
    PREADY ##1 !PREADY;
  endsequence
  // shadow control word, so checks know which options are on
  always_comb
  begin
    c_nxt = c_r;
    if (PSEL && PENABLE && !PREADY && PWRITE && PADDR == 12'h000) c_nxt = PWDATA[6:0];
  end
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST) c_r <= 7'h00; else c_r <= c_nxt;
  // current and low-voltage limits stay at reset values; the bench never writes them
  AST_OFF: assert property (ALARM |-> !PWR_EN && !DRV_EN) else $error("power on in alarm");
  AST_ICUR: assert property (MEAS.icur > 16'h0FA0 |=> ALARM) else $error("no current alarm");
  AST_LOWV: assert property (c_r[0] && MEAS.vin <= 16'h1F40 |=> ALARM) else $error("no low alarm");
  AST_OVHT: assert property (c_r[1] && EVT.ovht |=> ALARM && !DRV_EN) else $error("no heat alarm");
  AST_BRDG: assert property (c_r[2] && EVT.brdg |=> ALARM && !DRV_EN) else $error("no bridge alarm");
  AST_MISS: assert property (c_r[3] && (EVT.lsw_right && EVT.mov_left || EVT.lsw_left && EVT.mov_right)
    |=> ALARM) else $error("no misset alarm");
  AST_STCK: assert property (c_r[4] && ALARM && !(PSEL && PWRITE) |=> ALARM) else $error("sticky lost");
  AST_USB: assert property (c_r[5] && $rose(EVT.link_broken) |=> USB_LINK_RST [*8]) else $error("no usb reset");
  AST_RDY: assert property (s_acc |=> s_ack) else $error("bad ready");
  AST_ERR: assert property (PSLVERR |-> PREADY) else $error("error without ready");
endmodule
bind sfam_monitor sfam_chk u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEAS(MEAS),
  .EVT(EVT), .PWR_EN(PWR_EN), .DRV_EN(DRV_EN), .ALARM(ALARM), .USB_LINK_RST(USB_LINK_RST));

// ===== test/sfam_host.sv
`timescale 1ns/1ps
module sfam_host (
  // clock, reset, bench control
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic drop,
  // link
  input  wire logic link_rst,
  output logic      broken
);
  logic b_r, b_nxt;
  // a broken link stays broken until the device restarts it
  always_comb b_nxt = link_rst ? 1'b0 : (drop ? 1'b1 : b_r);
  always_ff @(posedge clk or posedge rst)
    if (rst) b_r <= 1'b0; else b_r <= b_nxt;
  assign broken = b_r;
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sfam_pkg::*;
  typedef struct {logic [6:0] c; int f; logic [15:0] v; logic [31:0] e;} sfam_row_s;
  localparam sfam_meas_s NOM = {16'h0000, 16'h2000, 16'h0000, 16'h1200, 16'h0000};
  logic        clk_sys = 0, rst = 1, psel = 0, pen = 0, pwr = 0, drop = 0, brk, prdy, perr, er;
  logic        pwr_en, drv_en, alarm, usb_rst;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0, rd, prdata;
  logic [6:1]  ev = 6'h00;
  sfam_meas_s  meas = NOM, m;
  sfam_evt_s   evt;
  int          fails = 0, n_checks = 0, n;
  // field 5 means discrete events, others a measured value
  sfam_row_s rows[12] = '{'{7'h00, 0, 16'h0FA1, 32'h10001}, '{7'h00, 1, 16'h3001, 32'h10002},
    '{7'h00, 2, 16'h01C3, 32'h10004}, '{7'h00, 3, 16'h1451, 32'h10008}, '{7'h00, 3, 16'h1067, 32'h10010},
    '{7'h40, 4, 16'h0051, 32'h10020}, '{7'h00, 4, 16'h0051, 32'h0}, '{7'h01, 1, 16'h1F40, 32'h10040},
    '{7'h02, 5, 16'h0040, 32'h10080}, '{7'h00, 5, 16'h0040, 32'h0}, '{7'h04, 5, 16'h0020, 32'h10100},
    '{7'h08, 5, 16'h000C, 32'h10200}};
  assign evt = {ev, brk};
  sfam_monitor uut (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
    .PWDATA(pwd), .PRDATA(prdata), .PREADY(prdy), .PSLVERR(perr), .MEAS(meas), .EVT(evt),
    .PWR_EN(pwr_en), .DRV_EN(drv_en), .ALARM(alarm), .USB_LINK_RST(usb_rst));
  sfam_host host (.clk(clk_sys), .rst(rst), .drop(drop), .link_rst(usb_rst), .broken(brk));
  always #4 clk_sys = ~clk_sys;
  task complete_run;
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      $display("ERROR %s exp %h got %h", s, e, g);
      fails++;
    end
  endtask
  // one apb transfer; read data and error are taken at the ready edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1; pwr <= w; padr <= a; pwd <= d;
    @(posedge clk_sys);
    pen <= 1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_sys);
      if (prdy === 1'b1) break;
    end
    rd = prdata; er = perr;
    psel <= 0; pen <= 0;
    if (i == 20)
    begin
      fails++;
      complete_run;
    end
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 0;
    apb(0, 12'h000, 0); chk("ctrl", rd, 32'h0);
    apb(0, 12'h004, 0); chk("icur lim", rd, 32'h0FA0);
    apb(1, 12'h008, 32'h3000); apb(0, 12'h008, 0); chk("vmax lim", rd, 32'h3000);
    apb(0, 12'h030, 0); chk("unmapped", {er, rd[30:0]}, 32'h80000000);
    foreach (rows[k])
    begin
      apb(1, 12'h000, {25'h0, rows[k].c});
      m = NOM;
      if (rows[k].f < 5) m[79-16*rows[k].f -: 16] = rows[k].v;
      meas <= m;
      ev <= (rows[k].f == 5) ? rows[k].v[6:1] : 6'h00;
      repeat (3) @(posedge clk_sys);
      apb(0, 12'h020, 0); chk("status", rd, rows[k].e);
      chk("outs", {29'h0, alarm, pwr_en, drv_en}, rows[k].e[16] ? 32'h4 : 32'h3);
      meas <= NOM; ev <= 6'h00;
      repeat (3) @(posedge clk_sys);
      chk("cleared", {31'h0, alarm}, 32'h0);
    end
    // sticky: cause goes away but alarm holds until stop
    apb(1, 12'h000, 32'h10);
    m = NOM; m.icur = 16'h0FA1; meas <= m;
    repeat (3) @(posedge clk_sys);
    meas <= NOM;
    repeat (3) @(posedge clk_sys);
    apb(0, 12'h020, 0); chk("sticky", {alarm, rd[30:0]}, 32'h80010001);
    apb(1, 12'h024, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("stopped", {31'h0, alarm}, 32'h0);
    // usb reconnect pulse length
    apb(1, 12'h000, 32'h20);
    drop <= 1;
    @(posedge clk_sys);
    drop <= 0; n = 0;
    repeat (40) @(posedge clk_sys) if (usb_rst === 1'b1) n++;
    chk("usb rst", n, 32'h10);
    // mid-run reset drops a latched alarm and brings the defaults back
    apb(1, 12'h000, 32'h10);
    meas <= m;
    repeat (3) @(posedge clk_sys);
    chk("latched", {31'h0, alarm}, 32'h1);
    rst <= 1;
    meas <= NOM;
    @(posedge clk_sys);
    chk("in reset", {28'h0, alarm, pwr_en, drv_en, usb_rst}, 32'h0);
    rst <= 0;
    repeat (2) @(posedge clk_sys);
    chk("after reset", {29'h0, alarm, pwr_en, drv_en}, 32'h3);
    apb(0, 12'h008, 0);
    chk("vmax reset", rd, 32'hFFFF);
    chk("no error", {31'h0, er}, 32'h0);
    // with reconnect off a broken link is left alone
    drop <= 1;
    @(posedge clk_sys);
    drop <= 0;
    n = 0;
    repeat (30) @(posedge clk_sys) if (usb_rst === 1'b1) n++;
    chk("usb off", n, 32'h0);
    complete_run;
  end
endmodule
